// file: rtl/sric_pkg.sv
// Constants, glyphs and states of the safety receiver interlock block.
package sric_pkg;
  // Core clock and the derived millisecond timebase.
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / MS_PER_S;
  // Times in milliseconds, counted on the millisecond tick.
  localparam logic [11:0] PRESS_MIN_MS = 12'h096;   // 0.15 s.
  localparam logic [11:0] PRESS_MAX_MS = 12'hfa0;   // 4 s.
  localparam logic [13:0] AUTO_CLEAR_MS = 14'h2710; // 10 s.
  localparam logic [12:0] ALIGN_MS = 13'h1388;      // 5 s.
  localparam logic [9:0] FB_WINDOW_MS = 10'h1f4;    // 500 ms.
  localparam logic [9:0] CHAR_MS = 10'h3e8;         // One glyph per second.
  localparam logic [9:0] SLOW_HALF_MS = 10'h1f4;    // Half period of 1 Hz.
  localparam logic [9:0] FAST_HALF_MS = 10'h032;    // Half period of 10 Hz.
  // Error classes.
  localparam logic [1:0] CLS_INTERNAL = 2'h0;
  localparam logic [1:0] CLS_EXTERNAL = 2'h1;
  localparam logic [1:0] CLS_USAGE = 2'h2;
  // Feedback timing error codes, two decimal digits.
  localparam logic [7:0] FEEDBACK_OPEN_TIMEOUT_CODE = 8'h30;
  localparam logic [7:0] FEEDBACK_CLOSE_TIMEOUT_CODE = 8'h31;
  // Named glyph indices: the digit 8, the letters t and C, and the channel digits.
  localparam logic [3:0] G_EIGHT = 4'h8;
  localparam logic [3:0] G_T = 4'ha;
  localparam logic [3:0] G_C = 4'hb;
  localparam logic [3:0] CHANNEL_ONE_CODE = 4'h1;
  localparam logic [3:0] CHANNEL_TWO_CODE = 4'h2;
  // Segment patterns, bit order g f e d c b a.
  localparam logic [6:0] GLYPH [16] = '{
    7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d, 7'h7d, 7'h07,
    7'h7f, 7'h6f, 7'h78, 7'h39, 7'h71, 7'h79, 7'h3e, 7'h00};
  // Display modes in falling priority after the start sequence.
  localparam logic [1:0] MODE_START = 2'h0;
  localparam logic [1:0] MODE_ERR = 2'h1;
  localparam logic [1:0] MODE_ALIGN = 2'h2;
  localparam logic [1:0] MODE_CHAN = 2'h3;
  // Control states of the receiver.
  typedef enum logic [2:0] {
    ST_START = 3'h0,
    ST_LOCKED = 3'h1,
    ST_ON = 3'h2,
    ST_ERR = 3'h3,
    ST_FAULT = 3'h4
  } sric_state_type;
endpackage

// file: rtl/sric_receiver.sv
// Receiver control: interlock, feedback check, display and indicators.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Power-up shows 8, then response time code.
// - Errors carry class letter F, E or U.
// - Show letter then code, cycling while present.
// - Non-locking errors clear after 10 s, locked.
// - Blocking error holds until power cycle.
// - Alignment mode if unaligned or interrupted 5 s.
// - Field split in three areas, three segments.
// - Segment lit, flashing or dark by area.
// - Field free 5 s leaves alignment mode.
// - Outputs stay off after intrusion until reset.
// - Interlock active from receiver wiring alone.
// - Valid reset with free field switches on.
// - Feedback monitoring selected by wiring.
// - Feedback must be closed before switch-on.
// - Feedback must open within 500 ms after on.
// - Feedback must close within 500 ms after off.
// - Feedback violation: off, code, fault lock.
// - Channel one default, reversed supply selects two.
// - Yellow lit only locked with free field.
// - Red off, green on, flashing per error class.
module sric_receiver
  import sric_pkg::*;
#(
  parameter int BEAMS = 48,
  parameter logic [17:0] TICK_CYCLES = 18'(CYC_PER_MS),
  parameter int RESP_MS = 10
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [BEAMS-1:0] field_clear_i,
  input wire logic reset_button_i,
  input wire logic feedback_closed_i,
  input wire logic supply_reversed_i,
  input wire logic interlock_wired_i,
  input wire logic feedback_wired_i,
  input wire logic error_valid_i,
  input wire logic [1:0] error_class_i,
  input wire logic [7:0] error_code_i,
  input wire logic error_locking_i,
  output logic [1:0] safety_output_pair_o,
  output logic [6:0] seg_o,
  output logic led_red_o,
  output logic led_green_o,
  output logic led_yellow_o,
  output logic channel_two_o
);
  localparam int AREA = BEAMS / 3;
  localparam int SW = BEAMS + 5;
  localparam logic [3:0] RESP_TENS = 4'((RESP_MS / 10) % 10);
  localparam logic [3:0] RESP_UNITS = 4'(RESP_MS % 10);

  // Two-flop synchroniser for every pin input except rst_i and the error report inputs.
  logic [SW-1:0] meta;
  logic [SW-1:0] sync;
  always_ff @(posedge clk_i) begin
    meta <= {field_clear_i, reset_button_i, feedback_closed_i,
             supply_reversed_i, interlock_wired_i, feedback_wired_i};
    sync <= meta;
  end

  // Named views of the synchronised inputs.
  wire [BEAMS-1:0] beams = sync[SW-1:5];
  wire button = sync[4];
  wire fb_closed = sync[3];
  wire reversed = sync[2];
  wire interlock_en = sync[1];
  wire fb_mon_en = sync[0];
  wire field_free = &beams;

  // Millisecond tick from the core clock.
  logic [17:0] pre;
  wire tick = (pre == TICK_CYCLES - 18'h1);
  always_ff @(posedge clk_i) begin
    if (rst_i || tick) begin
      pre <= 18'h0;
    end else begin
      pre <= pre + 18'h1;
    end
  end

  // Slow and fast flash phases for segments and indicators.
  logic [9:0] slow_ms;
  logic [9:0] fast_ms;
  logic slow_blink;
  logic fast_blink;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      slow_ms <= 10'h0;
      fast_ms <= 10'h0;
      slow_blink <= 1'b0;
      fast_blink <= 1'b0;
    end else if (tick) begin
      slow_ms <= (slow_ms == SLOW_HALF_MS - 10'h1) ? 10'h0 : slow_ms + 10'h1;
      fast_ms <= (fast_ms == FAST_HALF_MS - 10'h1) ? 10'h0 : fast_ms + 10'h1;
      if (slow_ms == SLOW_HALF_MS - 10'h1) begin
        slow_blink <= ~slow_blink;
      end
      if (fast_ms == FAST_HALF_MS - 10'h1) begin
        fast_blink <= ~fast_blink;
      end
    end
  end

  // Reset button: time the press, judge it on release.
  logic btn_q;
  logic [11:0] press_ms;
  wire released = btn_q && !button;
  wire press_ok = released && press_ms >= PRESS_MIN_MS
                  && press_ms <= PRESS_MAX_MS;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      btn_q <= 1'b0;
      press_ms <= 12'h0;
    end else begin
      btn_q <= button;
      if (!button) begin
        press_ms <= 12'h0;
      end else if (tick && press_ms <= PRESS_MAX_MS) begin
        press_ms <= press_ms + 12'h1;
      end
    end
  end

  // Control state and captured error.
  sric_state_type state;
  sric_state_type next_state;
  logic [1:0] err_cls;
  logic [7:0] err_code;
  logic [13:0] err_ms;
  logic wait_open;
  logic wait_close;
  logic [9:0] fb_ms;
  logic seq_done;

  // Feedback timing checks, fired when the window has run out.
  wire fb_fail_open = wait_open && fb_closed
                      && fb_ms == FB_WINDOW_MS;
  wire fb_fail_close = wait_close && !fb_closed
                       && fb_ms == FB_WINDOW_MS;
  wire fb_fail = (fb_fail_open || fb_fail_close) && state != ST_FAULT;
  // Feedback must be closed and settled before switch-on.
  wire fb_ready = !fb_mon_en || (fb_closed && !wait_close);
  // Wiring alone arms the interlock; a valid press releases it.
  wire release_ok = interlock_en ? press_ok : 1'b1;
  wire switch_on = field_free && fb_ready && release_ok;
  wire err_in = error_valid_i && state != ST_FAULT;

  // Next state: faults first, then new errors, then normal flow.
  always_comb begin
    next_state = state;
    if (fb_fail || (err_in && error_locking_i)) begin
      next_state = ST_FAULT;
    end else if (err_in) begin
      next_state = ST_ERR;
    end else begin
      unique case (state)
        ST_START: if (seq_done) next_state = ST_LOCKED;
        ST_LOCKED: if (switch_on) next_state = ST_ON;
        ST_ON: if (!field_free) next_state = ST_LOCKED;
        ST_ERR: begin
          if (tick && err_ms == AUTO_CLEAR_MS - 14'h1) begin
            next_state = ST_LOCKED;
          end
        end
        ST_FAULT: next_state = ST_FAULT;
        default: next_state = ST_FAULT;
      endcase
    end
  end

  // State register, error capture and the auto-clear timer.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_START;
      err_cls <= CLS_INTERNAL;
      err_code <= 8'h0;
      err_ms <= 14'h0;
    end else begin
      state <= next_state;
      err_ms <= (state == ST_ERR && tick) ? err_ms + 14'h1 : err_ms;
      if (fb_fail) begin
        err_cls <= CLS_EXTERNAL;
        err_code <= fb_fail_open ? FEEDBACK_OPEN_TIMEOUT_CODE
                                 : FEEDBACK_CLOSE_TIMEOUT_CODE;
      end else if (err_in) begin
        err_cls <= error_class_i;
        err_code <= error_code_i;
        err_ms <= 14'h0;
      end
    end
  end

  // Dynamic feedback watch around each switch-on and switch-off.
  wire entering = next_state == ST_ON && state != ST_ON;
  wire leaving = state == ST_ON && next_state != ST_ON;
  always_ff @(posedge clk_i) begin
    if (rst_i || !fb_mon_en) begin
      wait_open <= 1'b0;
      wait_close <= 1'b0;
      fb_ms <= 10'h0;
    end else if (entering) begin
      wait_open <= 1'b1;
      wait_close <= 1'b0;
      fb_ms <= 10'h0;
    end else if (leaving) begin
      wait_open <= 1'b0;
      wait_close <= 1'b1;
      fb_ms <= 10'h0;
    end else begin
      wait_open <= wait_open && fb_closed;
      wait_close <= wait_close && !fb_closed;
      if ((wait_open || wait_close) && tick) begin
        fb_ms <= fb_ms + 10'h1;
      end
    end
  end

  // Alignment mode: starts set, toggles after 5 s of steady field.
  logic align;
  logic [12:0] field_ms;
  wire steady = align ? field_free : !field_free;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      align <= 1'b1;
      field_ms <= 13'h0;
    end else if (field_ms == ALIGN_MS) begin
      align <= ~align;
      field_ms <= 13'h0;
    end else if (!steady) begin
      field_ms <= 13'h0;
    end else if (tick) begin
      field_ms <= field_ms + 13'h1;
    end
  end

  // Segment state of one beam area: lit, flashing or dark.
  function automatic logic area_seg(input logic all_c, input logic any_c,
                                    input logic blink);
    area_seg = all_c || (any_c && blink);
  endfunction

  // Three equal beam areas, bottom, middle and top.
  logic [2:0] area_on;
  for (genvar k = 0; k < 3; k++) begin : g_area
    wire [AREA-1:0] part = beams[k*AREA +: AREA];
    assign area_on[k] = area_seg(&part, |part, slow_blink);
  end

  // Display mode by priority.
  wire in_err = state == ST_ERR || state == ST_FAULT;
  wire [1:0] mode = (state == ST_START) ? MODE_START
                  : in_err ? MODE_ERR
                  : align ? MODE_ALIGN : MODE_CHAN;
  wire [1:0] last_phase = (mode == MODE_START) ? 2'h3
                        : (mode == MODE_ERR) ? 2'h2 : 2'h1;

  // Glyph sequencer, restarted on every mode change.
  logic [1:0] mode_q;
  logic [1:0] phase;
  logic [9:0] char_ms;
  wire char_end = tick && char_ms == CHAR_MS - 10'h1;
  assign seq_done = mode == MODE_START && phase == 2'h3 && char_end;
  always_ff @(posedge clk_i) begin
    if (rst_i || mode != mode_q) begin
      phase <= 2'h0;
      char_ms <= 10'h0;
    end else if (char_end) begin
      char_ms <= 10'h0;
      phase <= (phase == last_phase) ? 2'h0 : phase + 2'h1;
    end else if (tick) begin
      char_ms <= char_ms + 10'h1;
    end
  end

  // Glyph choice per mode and phase.
  wire [3:0] cls_glyph = {2'h3, err_cls};
  wire [3:0] chan_glyph = reversed ? CHANNEL_TWO_CODE : CHANNEL_ONE_CODE;
  wire [3:0] start_glyph = (phase == 2'h0) ? G_EIGHT
                         : (phase == 2'h1) ? G_T
                         : (phase == 2'h2) ? RESP_TENS : RESP_UNITS;
  wire [3:0] err_glyph = (phase == 2'h0) ? cls_glyph
                       : (phase == 2'h1) ? err_code[7:4] : err_code[3:0];
  wire [3:0] chan_show = (phase == 2'h0) ? G_C : chan_glyph;
  wire [6:0] align_seg = {area_on[1], 2'h0, area_on[0], 2'h0, area_on[2]};
  wire [6:0] next_seg = (mode == MODE_START) ? GLYPH[start_glyph]
                      : (mode == MODE_ERR) ? GLYPH[err_glyph]
                      : (mode == MODE_ALIGN) ? align_seg
                      : GLYPH[chan_show];

  // Indicator drive.
  wire err_flash = (err_cls == CLS_INTERNAL) ? fast_blink : slow_blink;
  wire next_red = in_err ? err_flash : next_state != ST_ON;
  wire next_yellow = interlock_en && state == ST_LOCKED
                     && field_free;

  // Output registers.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_q <= MODE_START;
      seg_o <= 7'h0;
      safety_output_pair_o <= 2'h0;
      led_red_o <= 1'b0;
      led_green_o <= 1'b0;
      led_yellow_o <= 1'b0;
      channel_two_o <= 1'b0;
    end else begin
      mode_q <= mode;
      seg_o <= next_seg;
      safety_output_pair_o <= {2{next_state == ST_ON}};
      led_red_o <= next_red;
      led_green_o <= next_state == ST_ON;
      led_yellow_o <= next_yellow;
      channel_two_o <= reversed;
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Checks on the control flow.
  chk_fault_sticky: assert property (
    state == ST_FAULT |=> state == ST_FAULT && safety_output_pair_o == 2'h0)
    else $error("fault state left or outputs on");
  chk_fb_fault: assert property (
    fb_fail |=> state == ST_FAULT && err_cls == CLS_EXTERNAL
    ##1 safety_output_pair_o == 2'h0)
    else $error("feedback violation not latched");
  chk_on_fb_closed: assert property (
    fb_mon_en && state == ST_LOCKED && !fb_closed |=> state != ST_ON)
    else $error("switch-on with open feedback");
  chk_press_window: assert property (
    interlock_en && state == ST_LOCKED && !press_ok |=> state != ST_ON)
    else $error("switch-on without valid press");
  chk_auto_clear: assert property (
    state == ST_ERR && !err_in && !fb_fail && tick
    && err_ms == AUTO_CLEAR_MS - 14'h1 |=> state == ST_LOCKED)
    else $error("timed clear missed");
  chk_start_off: assert property (
    state == ST_START |=> !led_green_o ##1 safety_output_pair_o != 2'h3
    || state != ST_START)
    else $error("outputs on during start sequence");
  chk_yellow_cause: assert property (
    led_yellow_o |-> $past(state) == ST_LOCKED && $past(field_free))
    else $error("yellow lit outside ready state");
  chk_green_on: assert property (
    safety_output_pair_o == 2'h3 |-> led_green_o && !led_red_o)
    else $error("indicator disagrees with outputs");
endmodule
`default_nettype wire

// file: verification/sric_machine_model.sv
// Contactor pair model whose feedback contacts follow the safety outputs.
`timescale 1ns/1ps
`default_nettype none
module sric_machine_model #(
  parameter int DELAY = 200
) (
  input wire logic clk_i,
  input wire logic [1:0] outputs_i,
  input wire logic [1:0] mode_i,
  output logic feedback_closed_o
);
  // Cycles since the outputs last switched.
  int count = 0;
  // Output level seen at the last edge.
  logic was_on = 1'b0;
  initial feedback_closed_o = 1'b1;
  // Mode 1 sticks closed, 2 never recloses, 3 stays open.
  always @(posedge clk_i) begin
    was_on <= &outputs_i;
    if (mode_i == 2'h3) begin
      feedback_closed_o <= 1'b0;
    end else if ((&outputs_i) != was_on) begin
      count <= 0;
    end else if (count < DELAY) begin
      count <= count + 1;
    end else if (was_on && mode_i != 2'h1) begin
      feedback_closed_o <= 1'b0;
    end else if (!was_on && mode_i != 2'h2) begin
      feedback_closed_o <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// file: verification/testbench.sv
// Self-checking bench of the receiver interlock block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import sric_pkg::*;
  localparam int TICK = 1;
  localparam int RESP = 37;
  localparam logic [3:0] G_F = 4'hc;
  localparam logic [3:0] G_E = 4'hd;
  localparam logic [3:0] G_U = 4'he;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [5:0] field = 6'h3f;
  logic button = 1'b0;
  logic fb_closed;
  logic reversed = 1'b0;
  logic fb_wired = 1'b1;
  logic err_valid = 1'b0;
  logic [1:0] err_class = 2'h0;
  logic [7:0] err_code = 8'h00;
  logic err_lock = 1'b0;
  logic [1:0] pair;
  logic [6:0] seg;
  logic red, green, yellow, chan_two;
  logic [1:0] fault_mode = 2'h0;
  logic [31:0] rnd = 32'h15;
  int miscompares = 0;
  int n_checks = 0;
  // The clock toggles every half period of 2 ns.
  always #2 clk_i = ~clk_i;
  sric_receiver #(.BEAMS(6), .TICK_CYCLES(18'h1), .RESP_MS(RESP)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .field_clear_i(field),
    .reset_button_i(button), .feedback_closed_i(fb_closed),
    .supply_reversed_i(reversed), .interlock_wired_i(1'b1),
    .feedback_wired_i(fb_wired), .error_valid_i(err_valid),
    .error_class_i(err_class), .error_code_i(err_code),
    .error_locking_i(err_lock), .safety_output_pair_o(pair),
    .seg_o(seg), .led_red_o(red), .led_green_o(green),
    .led_yellow_o(yellow), .channel_two_o(chan_two));
  sric_machine_model #(.DELAY(100 * TICK)) partner (
    .clk_i(clk_i), .outputs_i(pair), .mode_i(fault_mode),
    .feedback_closed_o(fb_closed));
  // Xorshift step for repeatable random stimulus.
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  // Compares one value and counts it.
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Waits a number of milliseconds of the block's timebase.
  task automatic ms(input int n);
    repeat (n * TICK) @(posedge clk_i);
  endtask
  // Holds the operator button for n ms, then lets the release sync in.
  task automatic press(input int n);
    button <= 1'b1;
    ms(n);
    button <= 1'b0;
    ms(5);
  endtask
  // Waits, bounded, for a glyph and checks it.
  task automatic wait_seg(input logic [6:0] exp);
    for (int k = 0; k < 1100 * TICK && seg !== exp; k++) @(posedge clk_i);
    check(seg, exp);
  endtask
  // Waits for the display to move on and checks the new glyph.
  task automatic next_seg(input logic [6:0] exp);
    logic [6:0] prev;
    prev = seg;
    for (int k = 0; k < 1100 * TICK && seg === prev; k++) @(posedge clk_i);
    check(seg, exp);
  endtask
  // Counts level changes of the red LED or of segment a over n ms.
  task automatic flips(input bit use_red, input int n, output int f);
    logic prev;
    f = 0;
    prev = use_red ? red : seg[0];
    repeat (n * TICK) begin
      @(posedge clk_i);
      if ((use_red ? red : seg[0]) !== prev) f++;
      prev = use_red ? red : seg[0];
    end
  endtask
  // Reports an error with two distinct random code digits.
  task automatic send_err(input logic [1:0] cls, input logic lock,
                          output logic [3:0] hi, output logic [3:0] lo);
    rnd = xs(rnd);
    hi = 4'(rnd % 10);
    lo = 4'((32'(hi) + 1 + (rnd >> 8) % 9) % 10);
    err_class <= cls;
    err_code <= {hi, lo};
    err_lock <= lock;
    err_valid <= 1'b1;
    @(posedge clk_i);
    err_valid <= 1'b0;
  endtask
  // Holds reset for six cycles, standing in for power-up.
  task automatic do_reset();
    rst_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask
  // Watchdog sized a little above the expected run.
  initial begin
    #220000;
    miscompares++;
    complete_run();
  end
  // Main sequence: normal interlock, feedback faults, locking errors.
  initial begin
    logic [3:0] hi, lo;
    int f;
    @(posedge clk_i);
    do_reset();
    check(pair, 8'h00);
    ms(20);
    check(seg, GLYPH[G_EIGHT]);
    next_seg(GLYPH[G_T]);
    next_seg(GLYPH[RESP / 10]);
    next_seg(GLYPH[RESP % 10]);
    ms(1100);
    field <= 6'h13;
    ms(10);
    check(seg[3], 8'h01);
    check(seg[6], 8'h00);
    check(yellow, 8'h00);
    flips(1'b0, 1500, f);
    check(8'(f >= 2), 8'h01);
    field <= 6'h3f;
    ms(10);
    check(yellow, 8'h01);
    check(pair, 8'h00);
    press(100);
    check(pair, 8'h00);
    press(200);
    check(pair, 8'h03);
    check({green, red}, 8'h02);
    ms(300);
    check(pair, 8'h03);
    rnd = xs(rnd);
    field <= ~6'(6'h1 << (rnd % 6));
    ms(5);
    check({pair, red}, 8'h01);
    field <= 6'h3f;
    ms(300);
    check({pair, yellow}, 8'h01);
    send_err(CLS_EXTERNAL, 1'b0, hi, lo);
    wait_seg(GLYPH[G_E]);
    next_seg(GLYPH[hi]);
    next_seg(GLYPH[lo]);
    next_seg(GLYPH[G_E]);
    flips(1'b1, 300, f);
    check(8'(f <= 1), 8'h01);
    ms(7500);
    check({pair, yellow}, 8'h01);
    wait_seg(GLYPH[G_C]);
    check(chan_two, 8'h00);
    next_seg(GLYPH[CHANNEL_ONE_CODE]);
    fault_mode <= 2'h1;
    press(200);
    check(pair, 8'h03);
    ms(600);
    check(pair, 8'h00);
    wait_seg(GLYPH[G_E]);
    next_seg(GLYPH[FEEDBACK_OPEN_TIMEOUT_CODE[7:4]]);
    next_seg(GLYPH[FEEDBACK_OPEN_TIMEOUT_CODE[3:0]]);
    press(200);
    check(pair, 8'h00);
    $display("Test of interlock and open timeout done");
    fault_mode <= 2'h3;
    reversed <= 1'b1;
    do_reset();
    ms(4100);
    check(chan_two, 8'h01);
    press(200);
    check(pair, 8'h00);
    fb_wired <= 1'b0;
    ms(5);
    press(200);
    check(pair, 8'h03);
    fault_mode <= 2'h2;
    fb_wired <= 1'b1;
    ms(5);
    field <= 6'h3e;
    ms(600);
    check(pair, 8'h00);
    wait_seg(GLYPH[G_E]);
    next_seg(GLYPH[FEEDBACK_CLOSE_TIMEOUT_CODE[7:4]]);
    next_seg(GLYPH[FEEDBACK_CLOSE_TIMEOUT_CODE[3:0]]);
    $display("Test of feedback wiring and close timeout done");
    fault_mode <= 2'h0;
    field <= 6'h3f;
    reversed <= 1'b0;
    do_reset();
    ms(4100);
    send_err(CLS_USAGE, 1'b0, hi, lo);
    wait_seg(GLYPH[G_U]);
    send_err(CLS_INTERNAL, 1'b1, hi, lo);
    wait_seg(GLYPH[G_F]);
    flips(1'b1, 300, f);
    check(8'(f >= 4), 8'h01);
    ms(10500);
    press(200);
    check(pair, 8'h00);
    $display("Test of error classes and locking done");
    complete_run();
  end
endmodule
`default_nettype wire
